/* shared/nasd_consts.vh */
// Operation codes, widths and field positions for the nibble datapath.
`ifndef NASD_CONSTS_VH
`define NASD_CONSTS_VH
`define NASD_OP_W 5
`define NASD_OP_NOP 5'h00
`define NASD_OP_LOAD_IMM 5'h01
`define NASD_OP_TABLE 5'h02
`define NASD_OP_BANK_UP 5'h03
`define NASD_OP_BANK_LO 5'h04
`define NASD_OP_ADD 5'h05
`define NASD_OP_ADDC 5'h06
`define NASD_OP_ADD_IMM 5'h07
`define NASD_OP_AND 5'h08
`define NASD_OP_OR 5'h09
`define NASD_OP_SET_CY 5'h0A
`define NASD_OP_CLR_CY 5'h0B
`define NASD_OP_TEST_CY 5'h0C
`define NASD_OP_CMA 5'h0D
`define NASD_OP_ROT 5'h0E
`define NASD_OP_BIT_SET 5'h0F
`define NASD_OP_BIT_CLR 5'h10
`define NASD_OP_BIT_TEST 5'h11
`define NASD_OP_CMP_MEM 5'h12
`define NASD_OP_CMP_IMM 5'h13
`define NASD_NIB_W 4
`define NASD_NIB_ZERO 4'h0
`define NASD_NIB_ONES 4'hF
`define NASD_NIB_ONE 4'h1
`define NASD_BIT_LSB 0
`define NASD_BIT_ONE 1
`define NASD_MEM_DEPTH 64
`define NASD_PTR_W 6
`define NASD_PTR_ZERO 6'h00
`define NASD_ROM_DEPTH 16384
`define NASD_ROM_AW 14
`define NASD_PAGE_W 6
`define NASD_PAGE_ZERO 6'h00
`define NASD_TADDR_W 3
`define NASD_TADDR_ZERO 3'h0
`define NASD_ROM_HI 7
`define NASD_ROM_HI_LO 4
`define NASD_ROM_LO_HI 3
`define NASD_BIT_MSB 3
`endif

/* core/nasd_datapath.v */
// Execution datapath of a 4-bit core for load, table, arithmetic, logic, bit and compare operations.
`include "nasd_consts.vh"

// What this block does
// RL1: Load-immediate writes immediate nibble n into the accumulator.
// RL2: Consecutive load-immediates after the first one are skipped.
// RL3: Table lookup puts ROM bits 7..4 in auxiliary, 3..0 in accumulator.
// RL4: In-page table address is three table-address bits above the accumulator.
// RL5: Table lookup uses one return stack level while executing.
// RL6: Upper bank select maps pages 64..127; lower bank maps 0..63.
// RL7: After reset the table bank is the lower bank.
// RL8: Plain add sums accumulator and memory nibble, carry untouched.
// RL9: Add with carry sums accumulator, memory and carry, sets carry out.
// RL10: Add immediate leaves carry, skips next when no overflow.
// RL11: AND accumulator with memory nibble into accumulator.
// RL12: OR accumulator with memory nibble into accumulator.
// RL13: Set carry forces carry to one.
// RL14: Clear carry forces carry to zero.
// RL15: Carry test skips next instruction when carry is zero.
// RL16: Complement inverts the accumulator.
// RL17: Rotate accumulator right through carry.
// RL18: Bit set forces bit j of memory nibble to one.
// RL19: Bit clear forces bit j of memory nibble to zero.
// RL20: Bit test skips next when bit j of memory nibble is zero.
// RL21: Memory compare skips next when accumulator equals memory nibble.
// RL22: Immediate compare skips next when accumulator equals n.
// RL23: A skipped instruction changes nothing except the load-run tracker, and still takes its cycle.
// RL24: All data are four bits wide, carry is one bit.
module nasd_datapath (
  input wire clock,
  input wire srst,
  input wire op_valid,
  input wire [`NASD_OP_W-1:0] op_code,
  input wire [`NASD_NIB_W-1:0] imm_n,
  input wire [1:0] imm_j,
  input wire [`NASD_PAGE_W-1:0] table_page,
  input wire [`NASD_TADDR_W-1:0] table_addr_high_bit,
  input wire [`NASD_PTR_W-1:0] memory_pointer,
  input wire rom_load,
  input wire [`NASD_ROM_AW-1:0] rom_load_addr,
  input wire [7:0] rom_load_data,
  input wire stack_full,
  output reg [`NASD_NIB_W-1:0] acc_r,
  output reg [`NASD_NIB_W-1:0] aux_r,
  output reg carry_bit,
  output reg upper_bank_r,
  output reg skip_r,
  output reg stack_use_r,
  output reg stack_overflow_r,
  output reg [`NASD_NIB_W-1:0] memory_at_pointer
);

  reg [`NASD_NIB_W-1:0] mem [0:`NASD_MEM_DEPTH-1];
  reg [7:0] rom [0:`NASD_ROM_DEPTH-1];
  reg last_load_r;
  reg [`NASD_NIB_W-1:0] acc_nxt;
  reg [`NASD_NIB_W-1:0] aux_nxt;
  reg carry_nxt;
  reg bank_nxt;
  reg skip_nxt;
  reg mem_we;
  reg [`NASD_NIB_W-1:0] mem_wdata;
  reg [`NASD_NIB_W:0] sum;
  wire [`NASD_NIB_W-1:0] mval;
  wire [`NASD_ROM_AW-1:0] rom_addr;
  wire [7:0] rom_word;
  wire exec;
  wire load_now;
  wire table_now;
  wire [`NASD_PAGE_W:0] page_sel;
  reg [`NASD_NIB_W-1:0] view_nxt;

  // One-hot nibble mask for bit j.
  function [`NASD_NIB_W-1:0] bit_mask;
    input [1:0] j;
    begin
      bit_mask = `NASD_NIB_ONE << j;
    end
  endfunction

  // Nibble with bit j forced to the given level and the other bits kept.
  function [`NASD_NIB_W-1:0] bit_write;
    input [`NASD_NIB_W-1:0] v;
    input [1:0] j;
    input level;
    begin
      bit_write = level ? (v | bit_mask(j)) : (v & ~bit_mask(j));
    end
  endfunction

  // Five-bit sum of two nibbles and a carry in; the top bit is the overflow.
  function [`NASD_NIB_W:0] nib_add;
    input [`NASD_NIB_W-1:0] a;
    input [`NASD_NIB_W-1:0] b;
    input cin;
    begin
      nib_add = {1'b0, a} + {1'b0, b} + {`NASD_NIB_ZERO, cin};
    end
  endfunction

  // True when a presented code names the given operation.
  function op_is;
    input [`NASD_OP_W-1:0] code;
    input [`NASD_OP_W-1:0] want;
    begin
      op_is = (code == want);
    end
  endfunction

  // Skipped instructions still arrive and use their cycle but do no work.
  assign exec = op_valid & ~skip_r; // see RL23
  // A load counts toward a load run even when it is itself skipped.
  assign load_now = op_valid & op_is(op_code, `NASD_OP_LOAD_IMM); // see RL2
  assign table_now = exec & op_is(op_code, `NASD_OP_TABLE); // see RL5
  assign mval = mem[memory_pointer];
  // The bank bit heads the page number, so the upper bank reaches the top half of the pages.
  assign page_sel = {upper_bank_r, table_page}; // see RL6
  // Page, then table-address bits above the accumulator.
  assign rom_addr = {page_sel, table_addr_high_bit, acc_r}; // see RL4
  assign rom_word = rom[rom_addr];

  always @*
  begin
    acc_nxt = acc_r;
    aux_nxt = aux_r;
    carry_nxt = carry_bit;
    bank_nxt = upper_bank_r;
    skip_nxt = 1'b0;
    mem_we = 1'b0;
    mem_wdata = mval;
    sum = {1'b0, `NASD_NIB_ZERO};
    view_nxt = mval;
    // Decode of the executed instruction; an unknown code acts as a no-operation.
    if (exec)
    begin
      case (op_code)
        `NASD_OP_LOAD_IMM:
        begin
          acc_nxt = imm_n; // see RL1
        end
        `NASD_OP_TABLE:
        begin
          aux_nxt = rom_word[`NASD_ROM_HI:`NASD_ROM_HI_LO]; // see RL3
          acc_nxt = rom_word[`NASD_ROM_LO_HI:`NASD_BIT_LSB]; // see RL3
        end
        `NASD_OP_BANK_UP:
        begin
          bank_nxt = 1'b1; // see RL6
        end
        `NASD_OP_BANK_LO:
        begin
          bank_nxt = 1'b0; // see RL6
        end
        `NASD_OP_ADD:
        begin
          sum = nib_add(acc_r, mval, 1'b0);
          acc_nxt = sum[`NASD_NIB_W-1:0]; // see RL8 see RL24
        end
        `NASD_OP_ADDC:
        begin
          sum = nib_add(acc_r, mval, carry_bit);
          acc_nxt = sum[`NASD_NIB_W-1:0]; // see RL9
          carry_nxt = sum[`NASD_NIB_W]; // see RL9
        end
        `NASD_OP_ADD_IMM:
        begin
          sum = nib_add(acc_r, imm_n, 1'b0);
          acc_nxt = sum[`NASD_NIB_W-1:0]; // see RL10
          skip_nxt = ~sum[`NASD_NIB_W]; // see RL10
        end
        `NASD_OP_AND:
        begin
          acc_nxt = acc_r & mval; // see RL11
        end
        `NASD_OP_OR:
        begin
          acc_nxt = acc_r | mval; // see RL12
        end
        `NASD_OP_SET_CY:
        begin
          carry_nxt = 1'b1; // see RL13
        end
        `NASD_OP_CLR_CY:
        begin
          carry_nxt = 1'b0; // see RL14
        end
        `NASD_OP_TEST_CY:
        begin
          skip_nxt = ~carry_bit; // see RL15
        end
        `NASD_OP_CMA:
        begin
          acc_nxt = acc_r ^ `NASD_NIB_ONES; // see RL16
        end
        `NASD_OP_ROT:
        begin
          acc_nxt = {carry_bit, acc_r[`NASD_BIT_MSB:`NASD_BIT_ONE]}; // see RL17
          carry_nxt = acc_r[`NASD_BIT_LSB]; // see RL17
        end
        `NASD_OP_BIT_SET:
        begin
          mem_we = 1'b1;
          mem_wdata = bit_write(mval, imm_j, 1'b1); // see RL18
        end
        `NASD_OP_BIT_CLR:
        begin
          mem_we = 1'b1;
          mem_wdata = bit_write(mval, imm_j, 1'b0); // see RL19
        end
        `NASD_OP_BIT_TEST:
        begin
          skip_nxt = ((mval & bit_mask(imm_j)) == `NASD_NIB_ZERO); // see RL20
        end
        `NASD_OP_CMP_MEM:
        begin
          skip_nxt = (acc_r == mval); // see RL21
        end
        `NASD_OP_CMP_IMM:
        begin
          skip_nxt = (acc_r == imm_n); // see RL22
        end
        default:
        begin
          skip_nxt = 1'b0;
        end
      endcase
    end
    // A load that follows a load is skipped, whether the first was executed or itself skipped.
    if (load_now && last_load_r)
    begin
      acc_nxt = acc_r; // see RL2
    end
    // The pointer view shows a bit write in the same cycle that it lands.
    if (mem_we)
    begin
      view_nxt = mem_wdata;
    end
  end

  // The fill port sets up table contents; it has no reset, so tables survive one.
  always @(posedge clock)
  begin
    if (rom_load)
    begin
      rom[rom_load_addr] <= rom_load_data;
    end
  end

  // Data memory keeps its contents through reset, as software expects.
  always @(posedge clock)
  begin
    if (mem_we)
    begin
      mem[memory_pointer] <= mem_wdata; // see RL18 see RL19
    end
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      acc_r <= `NASD_NIB_ZERO;
      aux_r <= `NASD_NIB_ZERO;
      carry_bit <= 1'b0;
      upper_bank_r <= 1'b0; // see RL7
      memory_at_pointer <= `NASD_NIB_ZERO;
    end
    else
    begin
      acc_r <= acc_nxt;
      aux_r <= aux_nxt;
      carry_bit <= carry_nxt;
      upper_bank_r <= bank_nxt;
      memory_at_pointer <= view_nxt;
    end
  end

  // Only a presented instruction moves the skip and load-run trackers; idle cycles leave both alone.
  always @(posedge clock)
  begin
    if (srst)
    begin
      skip_r <= 1'b0;
      last_load_r <= 1'b0;
    end
    else if (op_valid)
    begin
      skip_r <= skip_nxt; // see RL23
      last_load_r <= load_now; // see RL2
    end
  end

  // The lookup borrows a stack level; software must leave one free or it overflows.
  // The overflow mark is sticky so that a brief clash is not lost; only reset clears it.
  always @(posedge clock)
  begin
    if (srst)
    begin
      stack_use_r <= 1'b0;
      stack_overflow_r <= 1'b0;
    end
    else
    begin
      stack_use_r <= table_now; // see RL5
      if (table_now && stack_full)
      begin
        stack_overflow_r <= 1'b1; // see RL5
      end
    end
  end

endmodule // nasd_datapath

/* bench/nasd_checker.sv */
// Port assertions for the nibble datapath.
`include "nasd_consts.vh"
module nasd_checker (
  input wire clock,
  input wire srst,
  input wire op_valid,
  input wire [`NASD_OP_W-1:0] op_code,
  input wire [`NASD_NIB_W-1:0] imm_n,
  input wire [`NASD_NIB_W-1:0] acc_r,
  input wire carry_bit,
  input wire upper_bank_r,
  input wire skip_r
);
  timeunit 1ns;
  timeprecision 1ps;
  wire ex = op_valid && !skip_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  set_carry_a: assert property (ex && op_code == `NASD_OP_SET_CY |=> carry_bit) else $error("carry set");
  clr_carry_a: assert property (ex && op_code == `NASD_OP_CLR_CY |=> !carry_bit) else $error("carry clr");
  add_carry_a: assert property (ex && op_code == `NASD_OP_ADD |=> $stable(carry_bit)) else $error("add cy");
  add_imm_a: assert property (ex && op_code == `NASD_OP_ADD_IMM |=>
    $stable(carry_bit) && skip_r == ($past(acc_r) + $past(imm_n) < 16)) else $error("add imm");
  skip_none_a: assert property (op_valid && skip_r |=>
    $stable(acc_r) && $stable(carry_bit) && !skip_r) else $error("skipped op acted");
  skip_hold_a: assert property (skip_r && !op_valid |=> skip_r) else $error("skip lost");
  test_carry_a: assert property (ex && op_code == `NASD_OP_TEST_CY |=>
    skip_r == !$past(carry_bit)) else $error("carry test");
  cmp_imm_a: assert property (ex && op_code == `NASD_OP_CMP_IMM |=>
    skip_r == ($past(acc_r) == $past(imm_n))) else $error("imm compare");
  invert_acc_a: assert property (ex && op_code == `NASD_OP_CMA |=> acc_r == ~$past(acc_r)) else $error("cma");
  bank_reset_a: assert property ($fell(srst) |-> !upper_bank_r) else $error("bank after reset");
  cover property (ex && op_code == `NASD_OP_TABLE);
  cover property (op_valid && skip_r);
  cover property (ex && op_code == `NASD_OP_ADD_IMM ##1 skip_r);
endmodule // nasd_checker

/* bench/nasd_datapath_tb.sv */
// Self-checking bench for the nibble datapath.
`include "nasd_consts.vh"
module nasd_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clock = 0, srst = 1, op_valid = 0, rom_load = 0, stack_full = 0;
  reg [4:0] op_code = 5'h00;
  reg [3:0] imm_n = 4'h0;
  reg [1:0] imm_j = 2'h0;
  reg [5:0] table_page = 6'h05, memory_pointer = 6'h2A;
  reg [2:0] table_addr_high_bit = 3'h3;
  reg [13:0] rom_load_addr = 14'h0000;
  reg [7:0] rom_load_data = 8'h00;
  wire [3:0] acc_r, aux_r, memory_at_pointer;
  wire carry_bit, upper_bank_r, skip_r, stack_use_r, stack_overflow_r;
  integer num_errors = 0, tests_run = 0;
  always #12.5 clock = ~clock;
  nasd_datapath i_dut (.clock, .srst, .op_valid, .op_code, .imm_n, .imm_j, .table_page, .table_addr_high_bit,
    .memory_pointer, .rom_load, .rom_load_addr, .rom_load_data, .stack_full, .acc_r, .aux_r, .carry_bit,
    .upper_bank_r, .skip_r, .stack_use_r, .stack_overflow_r, .memory_at_pointer);
  task chk(input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Each instruction is valid for one cycle; results are read at the next falling edge.
  task op(input [4:0] c, input [3:0] n, input [1:0] j);
    @(negedge clock);
    op_valid = 1;
    op_code = c;
    imm_n = n;
    imm_j = j;
    @(negedge clock);
    op_valid = 0;
  endtask
  task p(input [4:0] c);
    op(c, 4'h0, 2'h0);
  endtask
  task sk(input [4:0] c, input [3:0] n, input [1:0] j, input e);
    op(c, n, j);
    chk(skip_r, e);
    p(`NASD_OP_NOP);
  endtask
  task set_mem(input [3:0] v);
    integer k;
    for (k = 0; k < 4; k = k + 1)
      op(v[k] ? `NASD_OP_BIT_SET : `NASD_OP_BIT_CLR, 4'h0, k[1:0]);
    chk(memory_at_pointer, v);
  endtask
  task rom_wr(input [13:0] a, input [7:0] d);
    @(negedge clock);
    rom_load = 1;
    rom_load_addr = a;
    rom_load_data = d;
    @(negedge clock);
    rom_load = 0;
  endtask
  task t_load;
    chk({upper_bank_r, carry_bit, skip_r, acc_r}, 8'h00);
    op(`NASD_OP_LOAD_IMM, 4'h5, 2'h0);
    chk(acc_r, 4'h5);
    op(`NASD_OP_LOAD_IMM, 4'h9, 2'h0);
    op(`NASD_OP_LOAD_IMM, 4'h3, 2'h0);
    chk(acc_r, 4'h5);
    p(`NASD_OP_CMA);
    chk(acc_r, 4'hA);
  endtask
  task t_logic;
    set_mem(4'hC);
    p(`NASD_OP_AND);
    chk(acc_r, 4'h8);
    op(`NASD_OP_LOAD_IMM, 4'h6, 2'h0);
    p(`NASD_OP_OR);
    chk(acc_r, 4'hE);
  endtask
  // Wrapping sums show the four-bit truncation as well as the carry handling.
  task t_add;
    p(`NASD_OP_CLR_CY);
    chk(carry_bit, 1'b0);
    op(`NASD_OP_LOAD_IMM, 4'h9, 2'h0);
    p(`NASD_OP_ADD);
    chk({carry_bit, acc_r}, 8'h05);
    p(`NASD_OP_SET_CY);
    chk(carry_bit, 1'b1);
    p(`NASD_OP_ADD);
    chk({carry_bit, acc_r}, 8'h11);
    p(`NASD_OP_ADDC);
    chk({carry_bit, acc_r}, 8'h0E);
    p(`NASD_OP_ADDC);
    chk({carry_bit, acc_r}, 8'h1A);
    p(`NASD_OP_ROT);
    chk({carry_bit, acc_r}, 8'h0D);
    p(`NASD_OP_ROT);
    chk({carry_bit, acc_r}, 8'h16);
  endtask
  task t_skip;
    op(`NASD_OP_ADD_IMM, 4'h4, 2'h0);
    chk({skip_r, carry_bit, acc_r}, 8'h3A);
    op(`NASD_OP_LOAD_IMM, 4'h0, 2'h0);
    chk({skip_r, acc_r}, 8'h0A);
    sk(`NASD_OP_ADD_IMM, 4'h6, 2'h0, 1'b0);
    chk({carry_bit, acc_r}, 8'h10);
    sk(`NASD_OP_TEST_CY, 4'h0, 2'h0, 1'b0);
    p(`NASD_OP_CLR_CY);
    sk(`NASD_OP_TEST_CY, 4'h0, 2'h0, 1'b1);
    sk(`NASD_OP_CMP_IMM, 4'h0, 2'h0, 1'b1);
    sk(`NASD_OP_CMP_IMM, 4'h1, 2'h0, 1'b0);
    sk(`NASD_OP_CMP_MEM, 4'h0, 2'h0, 1'b0);
    op(`NASD_OP_LOAD_IMM, 4'hC, 2'h0);
    sk(`NASD_OP_CMP_MEM, 4'h0, 2'h0, 1'b1);
    sk(`NASD_OP_BIT_TEST, 4'h0, 2'h0, 1'b1);
    sk(`NASD_OP_BIT_TEST, 4'h0, 2'h2, 1'b0);
  endtask
  task t_table;
    rom_wr({1'b0, 6'h05, 3'h3, 4'hC}, 8'hA7);
    rom_wr({1'b1, 6'h05, 3'h3, 4'h7}, 8'h5C);
    p(`NASD_OP_BANK_LO);
    p(`NASD_OP_TABLE);
    chk({aux_r, acc_r}, 8'hA7);
    chk({stack_use_r, stack_overflow_r}, 8'h02);
    p(`NASD_OP_BANK_UP);
    stack_full = 1;
    p(`NASD_OP_TABLE);
    chk({upper_bank_r, stack_overflow_r, aux_r, acc_r}, 16'h035C);
  endtask
  // A reset in mid-run must bring back the lower bank and drop the sticky overflow mark.
  task t_reset;
    p(`NASD_OP_SET_CY);
    srst = 1;
    stack_full = 0;
    repeat (2) @(negedge clock);
    srst = 0;
    chk({upper_bank_r, stack_overflow_r, carry_bit, skip_r, acc_r}, 16'h0000);
    op(`NASD_OP_LOAD_IMM, 4'hC, 2'h0);
    p(`NASD_OP_TABLE);
    chk({upper_bank_r, aux_r, acc_r}, 16'h00A7);
  endtask
  task print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    srst = 0;
    t_load;
    t_logic;
    t_add;
    t_skip;
    t_table;
    t_reset;
    print_verdict;
  end
  initial
  begin
    #20000;
    num_errors = num_errors + 1;
    print_verdict;
  end
endmodule // nasd_datapath_tb
bind nasd_datapath nasd_checker i_chk (.clock, .srst, .op_valid, .op_code, .imm_n, .acc_r, .carry_bit,
  .upper_bank_r, .skip_r);
